// file: hw/two_wire_pkg.sv
// Shared constants for the dual target two-wire slave and its bus master.
// Assumes a single 125 MHz core clock on both ends.
package two_wire_pkg;
  localparam logic [3:0] MEM_ID         = 4'ha;
  localparam logic [3:0] COMP_ID        = 4'hd;
  localparam int         ID_MSB         = 7;
  localparam int         ID_LSB         = 4;
  localparam int         SEL_MSB        = 2;
  localparam int         SEL_LSB        = 1;
  localparam int         RW_BIT         = 0;
  localparam int         BITS_PER_BYTE  = 8;
  localparam int         MEM_ADDR_W     = 15;
  localparam logic [7:0] COMP_FIRST     = 8'h09;
  localparam logic [7:0] COMP_LAST      = 8'h18;
  localparam logic [14:0] MEM_ADDR_RST  = 15'h0000;
  localparam logic [7:0] COMP_ADDR_RST  = 8'h09;
  localparam int         CLK_MHZ        = 125;
  localparam int         SCL_KHZ        = 400;
  localparam int         QTR_CYCLES     = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  localparam logic [7:0] QTR_COUNT      = 8'(QTR_CYCLES - 1);
endpackage : two_wire_pkg

// file: hw/two_wire_if.sv
// Two-wire bus between slave and master, open-drain wired-AND.
// Each end drives low when its enable is low (active-low enable).
`timescale 1ns/1ps
interface two_wire_if;
  logic scl_oe_n_m;
  logic sda_oe_n_m;
  logic sda_oe_n_s;
  wire  scl = scl_oe_n_m;
  wire  sda = sda_oe_n_m & sda_oe_n_s;
  modport slave  (input scl, input sda, output sda_oe_n_s);
  modport master (input scl, input sda, output scl_oe_n_m, output sda_oe_n_m);
endinterface : two_wire_if

// file: hw/two_wire_slave.sv
// Dual target two-wire slave: memory target and companion register target.
// Assumes SCL/SDA resolved by the interface; memory and register contents external.
// Functional notes
// - Memory ID 1010b claims memory target
// - Companion ID 1101b, memory untouched
// - Select bits match pins; bit0 direction
// - Start abandons everything, decode new address
// - Supply trip aborts; master restarts
// - Stop aborts pending operation
// - Ninth bit acknowledge; missing ack aborts
// - Reads continue on ack, end on nack
// - Master nacks final read byte
// - Memory address high then low byte
// - Unused upper address bits ignored
// - Increment before ack, wrap to zero
// - Memory address kept; companion never alters
// - Unlimited sequential bytes per operation
// - Companion address 09h..18h else nack
// - Bytes move most significant bit first
// - Write commits after eighth bit only
// - Read data starts right after address
// - Master ends read by nack/stop/start
// - Selective read via write then restart
// - Master holds SDA stable while SCL high
// - Companion address auto-increments independently
// - Master supplies address on every write
`timescale 1ns/1ps
module two_wire_slave (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  two_wire_if.slave        bus,
  input  wire logic [1:0]  dev_sel_in,
  input  wire logic        supply_trip_level_in,
  input  wire logic [7:0]  mem_rd_data_in,
  input  wire logic [7:0]  comp_rd_data_in,
  output logic [14:0]      mem_addr_out,
  output logic [7:0]       mem_wr_data_out,
  output logic             mem_wr_out,
  output logic [7:0]       comp_addr_out,
  output logic [7:0]       comp_wr_data_out,
  output logic             comp_wr_out,
  output logic             busy_out
);
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_DEVAD = 7'b0000010,
    S_ADDRH = 7'b0000100,
    S_ADDRL = 7'b0001000,
    S_WDATA = 7'b0010000,
    S_RDATA = 7'b0100000,
    S_RACK  = 7'b1000000
  } state_t;

  state_t      state;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_d;
  logic        sda_d;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic        is_comp;
  logic        ack_phase;
  logic        ack_drive;
  logic        sda_out;
  logic        ack_ok;
  logic [7:0]  tx;

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  wire byte_done = scl_rise & (bit_cnt == 4'(two_wire_pkg::BITS_PER_BYTE - 1)) & ~ack_phase;
  wire [3:0] rx_id = rx_byte[two_wire_pkg::ID_MSB:two_wire_pkg::ID_LSB];
  wire sel_ok = rx_byte[two_wire_pkg::SEL_MSB:two_wire_pkg::SEL_LSB] == dev_sel_in;
  wire id_mem  = (rx_id == two_wire_pkg::MEM_ID) & sel_ok;
  wire id_comp = (rx_id == two_wire_pkg::COMP_ID) & sel_ok;
  // The captured slave address stays in shift until its acknowledge slot ends
  wire rd_dir  = shift[two_wire_pkg::RW_BIT];
  wire comp_legal = (rx_byte >= two_wire_pkg::COMP_FIRST) & (rx_byte <= two_wire_pkg::COMP_LAST);
  wire abort = start_det | stop_det | supply_trip_level_in;
  wire [7:0] comp_next = (comp_addr_out == two_wire_pkg::COMP_LAST) ? two_wire_pkg::COMP_FIRST
                                                                     : comp_addr_out + 8'h01;

  assign tx = is_comp ? comp_rd_data_in : mem_rd_data_in;
  assign bus.sda_oe_n_s = ~((ack_drive) | (state == S_RDATA & ~sda_out));
  assign busy_out = (state != S_IDLE);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_d    <= scl_s;
      sda_d    <= sda_s;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state            <= S_IDLE;
      bit_cnt          <= 4'h0;
      shift            <= 8'h00;
      is_comp          <= 1'b0;
      ack_phase        <= 1'b0;
      ack_drive        <= 1'b0;
      ack_ok           <= 1'b0;
      sda_out          <= 1'b1;
      mem_addr_out     <= two_wire_pkg::MEM_ADDR_RST;
      mem_wr_data_out  <= 8'h00;
      mem_wr_out       <= 1'b0;
      comp_addr_out    <= two_wire_pkg::COMP_ADDR_RST;
      comp_wr_data_out <= 8'h00;
      comp_wr_out      <= 1'b0;
    end else begin
      mem_wr_out  <= 1'b0;
      comp_wr_out <= 1'b0;
      if (supply_trip_level_in) begin
        // Below trip the retained memory address is lost
        state        <= S_IDLE;
        ack_drive    <= 1'b0;
        mem_addr_out <= two_wire_pkg::MEM_ADDR_RST;
      end else if (start_det) begin
        state     <= S_DEVAD;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b0;
        ack_drive <= 1'b0;
      end else if (stop_det) begin
        state     <= S_IDLE;
        ack_drive <= 1'b0;
      end else if (state != S_IDLE) begin
        if (state == S_RDATA) begin
          if (scl_fall & ~ack_phase) begin
            sda_out <= shift[7];
            shift   <= {shift[6:0], 1'b1};
          end
          if (scl_rise & ~ack_phase) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'(two_wire_pkg::BITS_PER_BYTE - 1)) begin
              ack_phase <= 1'b1;
              if (is_comp) comp_addr_out <= comp_next;
              else mem_addr_out <= mem_addr_out + 15'h0001;
            end
          end
          if (scl_fall & ack_phase & bit_cnt == 4'(two_wire_pkg::BITS_PER_BYTE)) begin
            sda_out <= 1'b1;
            bit_cnt <= 4'h9;
          end
          if (scl_rise & ack_phase) begin
            if (sda_s) state <= S_IDLE;
            else begin
              ack_phase <= 1'b0;
              bit_cnt   <= 4'h0;
              shift     <= tx;
            end
          end
          if (scl_fall & ~ack_phase & bit_cnt == 4'h0) begin
            sda_out <= tx[7];
            shift   <= {tx[6:0], 1'b1};
          end
        end else begin
          if (scl_rise & ~ack_phase) begin
            shift   <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            ack_phase <= 1'b1;
            ack_ok    <= 1'b1;
            case (state)
              S_DEVAD: begin
                if (id_mem | id_comp) begin
                  is_comp <= id_comp;
                end else begin
                  ack_ok <= 1'b0;
                  state  <= S_IDLE;
                end
              end
              S_ADDRH: mem_addr_out[14:8] <= rx_byte[6:0];
              S_ADDRL: begin
                if (is_comp) begin
                  if (comp_legal) comp_addr_out <= rx_byte;
                  else ack_ok <= 1'b0;
                end else mem_addr_out[7:0] <= rx_byte;
              end
              S_WDATA: begin
                if (is_comp) begin
                  comp_wr_data_out <= rx_byte;
                  comp_wr_out      <= 1'b1;
                  comp_addr_out    <= comp_next;
                end else begin
                  mem_wr_data_out <= rx_byte;
                  mem_wr_out      <= 1'b1;
                  mem_addr_out    <= mem_addr_out + 15'h0001;
                end
              end
              default: ack_ok <= 1'b0;
            endcase
          end
          if (scl_fall & ack_phase & ~ack_drive & bit_cnt == 4'(two_wire_pkg::BITS_PER_BYTE)) begin
            if (ack_ok) begin
              ack_drive <= 1'b1;
              bit_cnt   <= 4'h9;
            end else state <= S_IDLE;
          end else if (scl_fall & ack_drive) begin
            ack_drive <= 1'b0;
            ack_phase <= 1'b0;
            bit_cnt   <= 4'h0;
            // Leave the address phase only once its ack is given, else the ack slot is skipped
            if (state == S_DEVAD) begin
              if (rd_dir) begin
                state   <= S_RDATA;
                sda_out <= tx[7];
                shift   <= {tx[6:0], 1'b1};
              end else state <= is_comp ? S_ADDRL : S_ADDRH;
            end else if (state == S_ADDRH) state <= S_ADDRL;
            else if (state == S_ADDRL) state <= S_WDATA;
          end
        end
      end
    end
  end
endmodule : two_wire_slave

// file: hw/two_wire_master.sv
// Two-wire bus master: one byte-level command at a time.
// Assumes the slave stretches no clock; SCL made here from a quarter-period enable.
`timescale 1ns/1ps
module two_wire_master (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  two_wire_if.master       bus,
  input  wire logic        cmd_valid_in,
  input  wire logic [2:0]  cmd_in,
  input  wire logic [7:0]  wr_byte_in,
  input  wire logic        ack_in,
  output logic             cmd_ready_out,
  output logic [7:0]       rd_byte_out,
  output logic             ack_seen_out,
  output logic             done_out
);
  // cmd_in: 0 start, 1 stop, 2 write byte, 3 read byte (ack_in 1 sends ack)
  typedef enum logic [3:0] {
    M_IDLE  = 4'b0001,
    M_START = 4'b0010,
    M_STOP  = 4'b0100,
    M_BIT   = 4'b1000
  } state_t;

  state_t      state;
  logic [7:0]  div;
  logic [1:0]  phase;
  logic [3:0]  bit_cnt;
  logic [8:0]  tx;
  logic [8:0]  rx;
  logic        rd_mode;
  logic        scl_o;
  logic        sda_o;

  wire tick = (div == two_wire_pkg::QTR_COUNT);

  assign bus.scl_oe_n_m = scl_o;
  assign bus.sda_oe_n_m = sda_o;
  assign cmd_ready_out  = (state == M_IDLE);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state        <= M_IDLE;
      div          <= 8'h00;
      phase        <= 2'h0;
      bit_cnt      <= 4'h0;
      tx           <= 9'h1ff;
      rx           <= 9'h000;
      rd_mode      <= 1'b0;
      scl_o        <= 1'b1;
      sda_o        <= 1'b1;
      rd_byte_out  <= 8'h00;
      ack_seen_out <= 1'b0;
      done_out     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      div      <= (state == M_IDLE | tick) ? 8'h00 : div + 8'h01;
      case (state)
        M_IDLE: begin
          phase <= 2'h0;
          if (cmd_valid_in) begin
            case (cmd_in)
              3'h0: state <= M_START;
              3'h1: state <= M_STOP;
              3'h2: begin
                tx      <= {wr_byte_in, 1'b1};
                rd_mode <= 1'b0;
                bit_cnt <= 4'h0;
                state   <= M_BIT;
              end
              3'h3: begin
                tx      <= {8'hff, ~ack_in};
                rd_mode <= 1'b1;
                bit_cnt <= 4'h0;
                state   <= M_BIT;
              end
              default: done_out <= 1'b1;
            endcase
          end
        end
        M_START: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sda_o <= 1'b1;
            2'h1: scl_o <= 1'b1;
            2'h2: sda_o <= 1'b0;
            default: begin
              scl_o    <= 1'b0;
              done_out <= 1'b1;
              state    <= M_IDLE;
            end
          endcase
        end
        M_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sda_o <= 1'b0;
            2'h1: scl_o <= 1'b1;
            2'h2: sda_o <= 1'b1;
            default: begin
              done_out <= 1'b1;
              state    <= M_IDLE;
            end
          endcase
        end
        M_BIT: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sda_o <= tx[8];
            2'h1: scl_o <= 1'b1;
            2'h2: rx <= {rx[7:0], bus.sda};
            default: begin
              scl_o   <= 1'b0;
              tx      <= {tx[7:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                rd_byte_out  <= rx[8:1];
                ack_seen_out <= ~rx[0];
                done_out     <= 1'b1;
                sda_o        <= rd_mode ? 1'b1 : sda_o;
                state        <= M_IDLE;
              end
            end
          endcase
        end
        default: state <= M_IDLE;
      endcase
    end
  end
endmodule : two_wire_master

// file: tb/two_wire_monitor.sv
// Concurrent checks on the two-wire link and on the slave's memory side.
// Assumes one clock domain; instantiated by the bench beside the link interface.
`timescale 1ns/1ps
module two_wire_monitor (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        scl,
  input wire logic        sda,
  input wire logic        sda_oe_n_s,
  input wire logic        supply_trip_level_in,
  input wire logic [14:0] mem_addr_out,
  input wire logic        mem_wr_out,
  input wire logic        comp_wr_out,
  input wire logic        busy_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  sequence s_idle;
    !busy_out && sda_oe_n_s;
  endsequence
  property p_reset_idle;
    $fell(rst_in) |-> s_idle;
  endproperty
  property p_stop_idle;
    s_stop |-> ##[1:8] s_idle;
  endproperty
  property p_trip_abort;
    supply_trip_level_in |-> ##[0:3] s_idle;
  endproperty
  property p_trip_addr;
    supply_trip_level_in |-> ##[0:3] (mem_addr_out == 15'h0000);
  endproperty
  // Trip may cut the slave loose at any phase, so it is exempt here
  property p_sda_steady;
    disable iff (rst_in || supply_trip_level_in) !$stable(sda_oe_n_s) |-> !scl;
  endproperty
  property p_wr_inc;
    mem_wr_out |-> mem_addr_out == $past(mem_addr_out) + 15'h0001;
  endproperty
  property p_wr_ack;
    mem_wr_out |=> !mem_wr_out ##[0:300] !sda_oe_n_s;
  endproperty
  property p_comp_sep;
    comp_wr_out |-> !mem_wr_out && $stable(mem_addr_out);
  endproperty
  property p_idle_quiet;
    !busy_out |-> sda_oe_n_s;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("slave not idle after reset");
  a_stop_idle: assert property (p_stop_idle) else $error("slave not idle after stop");
  a_trip_abort: assert property (p_trip_abort) else $error("supply trip did not abort");
  a_trip_addr: assert property (p_trip_addr) else $error("supply trip kept memory address");
  a_sda_steady: assert property (p_sda_steady) else $error("slave moved data while clock high");
  a_wr_inc: assert property (p_wr_inc) else $error("memory address not stepped on write");
  a_wr_ack: assert property (p_wr_ack) else $error("write not followed by acknowledge");
  a_comp_sep: assert property (p_comp_sep) else $error("companion write touched memory");
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle slave drives data line");
endmodule : two_wire_monitor

// file: tb/testbench.sv
// Self-checking bench: slave and master joined on one link, user sides driven here.
// Assumes the package constants; reset is held for the first 16 cycles.
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] C_ST = 3'h0;
  localparam logic [2:0] C_SP = 3'h1;
  localparam logic [2:0] C_WR = 3'h2;
  localparam logic [2:0] C_RD = 3'h3;
  logic        sys_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        trip       = 1'b0;
  logic        cmd_valid  = 1'b0;
  logic [2:0]  cmd        = 3'h0;
  logic [7:0]  wr_byte    = 8'h00;
  logic        ack        = 1'b0;
  logic        cmd_ready, ack_seen, done, busy, mem_wr, comp_wr;
  logic [7:0]  rd_byte, mem_wd, comp_addr, comp_wd, prev_caddr;
  logic [14:0] mem_addr, prev_maddr;
  logic [22:0] wr_log [$];
  logic [15:0] cwr_log [$];
  int          n_fail   = 0;
  int          n_checks = 0;
  two_wire_if bif ();
  always #4 sys_clk_in = ~sys_clk_in;
  two_wire_slave u_two_wire_slave (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bif.slave), .dev_sel_in(2'h2),
    .supply_trip_level_in(trip), .mem_rd_data_in(mem_addr[7:0] ^ 8'h3c), .comp_rd_data_in(comp_addr ^ 8'h5a),
    .mem_addr_out(mem_addr), .mem_wr_data_out(mem_wd), .mem_wr_out(mem_wr), .comp_addr_out(comp_addr),
    .comp_wr_data_out(comp_wd), .comp_wr_out(comp_wr), .busy_out(busy));
  two_wire_master u_two_wire_master (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bif.master),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .wr_byte_in(wr_byte), .ack_in(ack), .cmd_ready_out(cmd_ready),
    .rd_byte_out(rd_byte), .ack_seen_out(ack_seen), .done_out(done));
  two_wire_monitor u_two_wire_monitor (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl(bif.scl), .sda(bif.sda),
    .sda_oe_n_s(bif.sda_oe_n_s), .supply_trip_level_in(trip), .mem_addr_out(mem_addr), .mem_wr_out(mem_wr),
    .comp_wr_out(comp_wr), .busy_out(busy));
  // Write strobes carry the address that was current before the step
  always @(posedge sys_clk_in) begin
    prev_maddr <= mem_addr;
    prev_caddr <= comp_addr;
    if (mem_wr) wr_log.push_back({mem_wd, prev_maddr});
    if (comp_wr) cwr_log.push_back({comp_wd, prev_caddr});
  end
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic quit();
    n_fail++;
    wrap_up();
  endtask : quit
  function automatic logic [7:0] dev(input logic [3:0] id, input logic rw);
    return {id, 1'b0, 2'h2, rw};
  endfunction : dev
  task automatic xfer(input logic [2:0] c, input logic [7:0] b, input logic a);
    int i;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge sys_clk_in);
    if (cmd_ready !== 1'b1) quit();
    cmd_valid = 1'b1;
    cmd = c;
    wr_byte = b;
    ack = a;
    @(negedge sys_clk_in);
    cmd_valid = 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge sys_clk_in);
    if (done !== 1'b1) quit();
  endtask : xfer
  task automatic wb(input logic [7:0] b, input logic e);
    xfer(C_WR, b, 1'b0);
    chk("ack", ack_seen, e);
  endtask : wb
  task automatic t_mem_write();
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::MEM_ID, 1'b0), 1'b1);
    wb(8'hff, 1'b1);
    wb(8'hff, 1'b1);
    wb(8'h5a, 1'b1);
    wb(8'ha5, 1'b1);
    xfer(C_SP, 8'h00, 1'b0);
    chk("wr top", wr_log[0], {8'h5a, 15'h7fff});
    chk("wr wrap", wr_log[1], {8'ha5, 15'h0000});
    chk("wr count", wr_log.size(), 23'h2);
    $display("Test memory write done");
  endtask : t_mem_write
  task automatic t_sel_read();
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::MEM_ID, 1'b0), 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h05, 1'b1);
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::MEM_ID, 1'b1), 1'b1);
    xfer(C_RD, 8'h00, 1'b1);
    chk("rd first", rd_byte, 8'h39);
    xfer(C_RD, 8'h00, 1'b0);
    chk("rd next", rd_byte, 8'h3a);
    xfer(C_SP, 8'h00, 1'b0);
    chk("mem addr", mem_addr, 15'h0007);
    $display("Test selective read done");
  endtask : t_sel_read
  task automatic t_companion();
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::COMP_ID, 1'b0), 1'b1);
    wb(8'h08, 1'b0);
    xfer(C_SP, 8'h00, 1'b0);
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::COMP_ID, 1'b0), 1'b1);
    wb(8'h18, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    xfer(C_SP, 8'h00, 1'b0);
    chk("comp last", cwr_log[0], {8'h11, 8'h18});
    chk("comp wrap", cwr_log[1], {8'h22, 8'h09});
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::COMP_ID, 1'b1), 1'b1);
    xfer(C_RD, 8'h00, 1'b0);
    xfer(C_SP, 8'h00, 1'b0);
    chk("comp rd", rd_byte, 8'h50);
    chk("mem addr", mem_addr, 15'h0007);
    chk("wr count", wr_log.size(), 23'h2);
    $display("Test companion done");
  endtask : t_companion
  task automatic t_select();
    xfer(C_ST, 8'h00, 1'b0);
    wb(8'ha2, 1'b0);
    xfer(C_SP, 8'h00, 1'b0);
    xfer(C_ST, 8'h00, 1'b0);
    wb(8'h54, 1'b0);
    xfer(C_SP, 8'h00, 1'b0);
    $display("Test select done");
  endtask : t_select
  task automatic t_trip();
    int i;
    xfer(C_ST, 8'h00, 1'b0);
    wb(dev(two_wire_pkg::MEM_ID, 1'b1), 1'b1);
    trip = 1'b1;
    for (i = 0; i < 8 && busy !== 1'b0; i++) @(negedge sys_clk_in);
    chk("busy", busy, 1'b0);
    chk("mem addr", mem_addr, 15'h0000);
    trip = 1'b0;
    xfer(C_ST, 8'h00, 1'b0);
    xfer(C_SP, 8'h00, 1'b0);
    $display("Test supply trip done");
  endtask : t_trip
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_mem_write();
    t_sel_read();
    t_companion();
    t_select();
    t_trip();
    wrap_up();
  end
endmodule : testbench
